// *** hdl/swrc_params.svh ***
// constants of the sleep, wake, reset and mode control block
`ifndef SWRC_PARAMS_SVH
`define SWRC_PARAMS_SVH

// register byte offsets (haddr[7:0])
`define SWRC_OFS_CONFIG   8'h00
`define SWRC_OFS_NVMODE   8'h04
`define SWRC_OFS_COMMAND  8'h08
`define SWRC_OFS_STATUS   8'h0C
`define SWRC_OFS_LEDPAT_A 8'h10
`define SWRC_OFS_LEDPAT_B 8'h14

// config field positions
`define SWRC_CFG_TRIM_LSB   0
`define SWRC_CFG_TRIM_MSB   4
`define SWRC_CFG_BRIGHT_LSB 8
`define SWRC_CFG_BRIGHT_MSB 11
`define SWRC_CFG_WDT_EN_BIT 16

// command bits, one-cycle effects
`define SWRC_CMD_RESET    0
`define SWRC_CMD_KICK     1
`define SWRC_CMD_STANDBY  2
`define SWRC_CMD_ACCESS   3
`define SWRC_CMD_LINK     4
`define SWRC_CMD_SLEEP    5

// status field positions
`define SWRC_ST_PHASE_LSB 0
`define SWRC_ST_RUN_LSB   8
`define SWRC_ST_MODE_BIT  12
`define SWRC_ST_TEST_BIT  13
`define SWRC_ST_WDT_BIT   14
`define SWRC_ST_PINS_LSB  16

// reset values
`define SWRC_RST_TRIM     5'h10
`define SWRC_RST_BRIGHT   4'hF
`define SWRC_RST_LEDPAT_A 32'hF0AA_0F11
`define SWRC_RST_LEDPAT_B 16'h55FF

// strap code {strap_pin_a, strap_pin_b, strap_select} for settings write
`define SWRC_STRAP_TEST   3'h2

// timing
`define SWRC_CLK_HZ       25000000
`define SWRC_INIT_MS      350
`define SWRC_WAKE_MS      85
`define SWRC_WDT_MS       1000
`define SWRC_LED_STEP_MS  125
`define SWRC_MS_CYCLES(ms) ((`SWRC_CLK_HZ / 1000) * (ms))

`endif

// *** hdl/swrc_pkg.sv ***
// types of the sleep, wake, reset and mode control block
package swrc_pkg;

  // power phase, one-hot
  typedef enum logic [4:0] {
    PH_INIT  = 5'h01,
    PH_RUN   = 5'h02,
    PH_SLEEP = 5'h04,
    PH_WAKE  = 5'h08,
    PH_DEEP  = 5'h10
  } swrc_phase_t;

  // run-time state of either operating state machine, one-hot
  typedef enum logic [2:0] {
    RS_STANDBY = 3'h1,
    RS_ACCESS  = 3'h2,
    RS_LINK    = 3'h4
  } swrc_run_t;

  // operating mode picked at startup
  typedef enum logic {
    MODE_AUTO = 1'b0,
    MODE_HOST = 1'b1
  } swrc_mode_t;

endpackage

// *** hdl/swrc_led.sv ***
// indicator blink sequencer with 16-level brightness
`timescale 1ns/1ps
`default_nettype none

module swrc_led #(
  parameter int STEP_CYCLES = 3125000
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       srst,
  input  wire logic [7:0] pattern,
  input  wire logic [3:0] bright,
  output var  logic       led_q
);

  logic [24:0] div_q;
  logic [2:0]  step_q;
  logic [3:0]  pwm_q;
  logic        tick;

  assign tick = (div_q == 25'(STEP_CYCLES - 1));

  // step divider: one enable pulse per blink step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= 25'h0;
      step_q <= 3'h0;
    end else if (srst) begin
      div_q  <= 25'h0;
      step_q <= 3'h0;
    end else if (tick) begin
      div_q  <= 25'h0;
      step_q <= step_q + 3'h1;
    end else begin
      div_q <= div_q + 25'h1;
    end
  end

  // free-running duty counter, 16 slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_q <= 4'h0;
    end else begin
      pwm_q <= pwm_q + 4'h1;
    end
  end

  // level n lights n+1 of 16 slots, so even level 0 stays visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_q <= 1'b0;
    end else if (srst) begin
      led_q <= 1'b0;
    end else begin
      led_q <= pattern[step_q] && (pwm_q <= bright);
    end
  end

endmodule

`default_nettype wire

// *** hdl/swrc_top.sv ***
// sleep, wake, reset and operating mode control with AHB-Lite registers
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "swrc_params.svh"

module swrc_top #(
  parameter int INIT_CYCLES = `SWRC_MS_CYCLES(`SWRC_INIT_MS),
  parameter int WAKE_CYCLES = `SWRC_MS_CYCLES(`SWRC_WAKE_MS),
  parameter int WDT_CYCLES  = `SWRC_MS_CYCLES(`SWRC_WDT_MS),
  parameter int LED_CYCLES  = `SWRC_MS_CYCLES(`SWRC_LED_STEP_MS)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        wake_n,
  input  wire logic        ext_rst_n,
  input  wire logic        sw_btn,
  input  wire logic        strap_select,
  input  wire logic        strap_pin_a,
  input  wire logic        strap_pin_b,
  input  wire logic        link_up,
  input  wire logic        page_active,
  input  wire logic        link_back,
  input  wire logic        low_battery,
  input  wire logic        uart_active,
  input  wire logic        low_power_req,
  output var  logic        status_out_a,
  output var  logic        status_out_b,
  output var  logic        indicator_led_out,
  output var  logic [4:0]  xtal_trim,
  output var  logic        uart_pipe_en
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic       wake_s;
  logic       ext_rst_s;
  logic       sw_btn_s;
  logic [2:0] strap_s;

  // first stage feeds only the second; idle levels are all high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
    end else begin
      pin_s1_q <= {wake_n, ext_rst_n, sw_btn, strap_pin_a, strap_pin_b, strap_select};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign wake_s    = pin_s2_q[5];
  assign ext_rst_s = pin_s2_q[4];
  assign sw_btn_s  = pin_s2_q[3];
  assign strap_s   = pin_s2_q[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic       addr_ph;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       cfg_wr;
  logic       nv_wr;
  logic       cmd_wr;
  logic       st_wr;
  logic       pa_wr;
  logic       pb_wr;
  logic       test_mode;

  assign addr_ph = hsel && hready && htrans[1];
  assign cfg_wr  = wr_pend_q && (wr_addr_q == `SWRC_OFS_CONFIG);
  assign nv_wr   = wr_pend_q && (wr_addr_q == `SWRC_OFS_NVMODE);
  assign cmd_wr  = wr_pend_q && (wr_addr_q == `SWRC_OFS_COMMAND);
  assign st_wr   = wr_pend_q && (wr_addr_q == `SWRC_OFS_STATUS);
  assign pa_wr   = wr_pend_q && (wr_addr_q == `SWRC_OFS_LEDPAT_A);
  assign pb_wr   = wr_pend_q && (wr_addr_q == `SWRC_OFS_LEDPAT_B);
  assign test_mode = (strap_s == `SWRC_STRAP_TEST);

  // write address held into the data phase, where hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // no wait states and no errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  swrc_pkg::swrc_mode_t mode_q;
  logic                 srst_q;
  logic                 wdt_en_q;
  logic [24:0]          wdt_cnt_q;
  logic                 wdt_fire;
  logic                 wdt_cause_q;
  logic                 host_rst_cmd;

  // the serial reset command only counts in host mode
  assign host_rst_cmd = cmd_wr && hwdata[`SWRC_CMD_RESET] && (mode_q == swrc_pkg::MODE_HOST);
  assign wdt_fire     = wdt_en_q && (wdt_cnt_q == 25'(WDT_CYCLES - 1));

  // any sample of a low pin resets; a pulse over 40 ns spans an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= !ext_rst_s || wdt_fire || host_rst_cmd;
    end
  end

  // watchdog counts while enabled; a kick restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_q <= 25'h0;
    end else if (srst_q || !wdt_en_q || (cmd_wr && hwdata[`SWRC_CMD_KICK])) begin
      wdt_cnt_q <= 25'h0;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 25'h1;
    end
  end

  // cause flag survives the reset it reports; a new expiry beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cause_q <= 1'b0;
    end else if (wdt_fire) begin
      wdt_cause_q <= 1'b1;
    end else if (st_wr && hwdata[`SWRC_ST_WDT_BIT]) begin
      wdt_cause_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [4:0]  trim_q;
  logic [3:0]  bright_q;
  logic        nv_mode_q;
  logic [31:0] pat_a_q;
  logic [15:0] pat_b_q;

  // volatile settings return to defaults on every reset source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_q   <= `SWRC_RST_TRIM;
      bright_q <= `SWRC_RST_BRIGHT;
      wdt_en_q <= 1'b0;
      pat_a_q  <= `SWRC_RST_LEDPAT_A;
      pat_b_q  <= `SWRC_RST_LEDPAT_B;
    end else if (srst_q) begin
      trim_q   <= `SWRC_RST_TRIM;
      bright_q <= `SWRC_RST_BRIGHT;
      wdt_en_q <= 1'b0;
      pat_a_q  <= `SWRC_RST_LEDPAT_A;
      pat_b_q  <= `SWRC_RST_LEDPAT_B;
    end else begin
      if (cfg_wr) begin
        trim_q   <= hwdata[`SWRC_CFG_TRIM_MSB:`SWRC_CFG_TRIM_LSB];
        bright_q <= hwdata[`SWRC_CFG_BRIGHT_MSB:`SWRC_CFG_BRIGHT_LSB];
        wdt_en_q <= hwdata[`SWRC_CFG_WDT_EN_BIT];
      end
      if (pa_wr) begin
        pat_a_q <= hwdata;
      end
      if (pb_wr) begin
        pat_b_q <= hwdata[15:0];
      end
    end
  end

  // stored mode is nonvolatile: only the straps unlock a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_mode_q <= 1'b0;
    end else if (nv_wr && test_mode) begin
      nv_mode_q <= hwdata[0];
    end
  end

  // trim code drives the load capacitor bank of the crystal oscillator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_trim <= `SWRC_RST_TRIM;
    end else begin
      xtal_trim <= trim_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power phase machine

  swrc_pkg::swrc_phase_t phase_q;
  swrc_pkg::swrc_phase_t phase_d;
  swrc_pkg::swrc_run_t   auto_q;
  swrc_pkg::swrc_run_t   host_q;
  swrc_pkg::swrc_run_t   run_st;
  logic [24:0]           ph_cnt_q;
  logic                  sleep_req;
  logic                  run_ph;

  assign run_ph = (phase_q == swrc_pkg::PH_RUN);
  assign run_st = (mode_q == swrc_pkg::MODE_HOST) ? host_q : auto_q;
  assign sleep_req = (mode_q == swrc_pkg::MODE_HOST)
                   ? (cmd_wr && hwdata[`SWRC_CMD_SLEEP])
                   : (low_power_req && (auto_q != swrc_pkg::RS_LINK));

  // deep sleep follows the power button in every phase
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      swrc_pkg::PH_INIT: begin
        if (!sw_btn_s) begin
          phase_d = swrc_pkg::PH_DEEP;
        end else if (ph_cnt_q == 25'(INIT_CYCLES - 1)) begin
          phase_d = swrc_pkg::PH_RUN;
        end
      end
      swrc_pkg::PH_RUN: begin
        if (!sw_btn_s) begin
          phase_d = swrc_pkg::PH_DEEP;
        end else if (sleep_req) begin
          phase_d = swrc_pkg::PH_SLEEP;
        end
      end
      swrc_pkg::PH_SLEEP: begin
        if (!sw_btn_s) begin
          phase_d = swrc_pkg::PH_DEEP;
        end else if (!wake_s) begin
          phase_d = swrc_pkg::PH_WAKE;
        end
      end
      swrc_pkg::PH_WAKE: begin
        if (!sw_btn_s) begin
          phase_d = swrc_pkg::PH_DEEP;
        end else if (ph_cnt_q == 25'(WAKE_CYCLES - 1)) begin
          phase_d = swrc_pkg::PH_RUN;
        end
      end
      swrc_pkg::PH_DEEP: begin
        if (sw_btn_s) begin
          phase_d = swrc_pkg::PH_INIT;
        end
      end
      default: begin
        phase_d = swrc_pkg::PH_INIT;
      end
    endcase
  end

  // phase register and its dwell counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q  <= swrc_pkg::PH_INIT;
      ph_cnt_q <= 25'h0;
    end else if (srst_q) begin
      phase_q  <= swrc_pkg::PH_INIT;
      ph_cnt_q <= 25'h0;
    end else begin
      phase_q  <= phase_d;
      ph_cnt_q <= (phase_d != phase_q) ? 25'h0 : ph_cnt_q + 25'h1;
    end
  end

  // mode is taken from the stored setting once per startup
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= swrc_pkg::MODE_AUTO;
    end else if (srst_q) begin
      mode_q <= swrc_pkg::MODE_AUTO;
    end else if (phase_q == swrc_pkg::PH_INIT && phase_d == swrc_pkg::PH_RUN) begin
      mode_q <= swrc_pkg::swrc_mode_t'(nv_mode_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state machines

  // automatic mode connects and falls back to access on link loss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_q <= swrc_pkg::RS_STANDBY;
    end else if (srst_q || !run_ph || mode_q != swrc_pkg::MODE_AUTO) begin
      auto_q <= swrc_pkg::RS_STANDBY;
    end else begin
      case (auto_q)
        swrc_pkg::RS_STANDBY: auto_q <= swrc_pkg::RS_ACCESS;
        swrc_pkg::RS_ACCESS: begin
          if (link_up) begin
            auto_q <= swrc_pkg::RS_LINK;
          end
        end
        swrc_pkg::RS_LINK: begin
          if (!link_up) begin
            auto_q <= swrc_pkg::RS_ACCESS;
          end
        end
        default: auto_q <= swrc_pkg::RS_STANDBY;
      endcase
    end
  end

  // host mode moves only on a command; link needs the radio to agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_q <= swrc_pkg::RS_STANDBY;
    end else if (srst_q || !run_ph || mode_q != swrc_pkg::MODE_HOST) begin
      host_q <= swrc_pkg::RS_STANDBY;
    end else if (cmd_wr) begin
      if (hwdata[`SWRC_CMD_STANDBY]) begin
        host_q <= swrc_pkg::RS_STANDBY;
      end else if (hwdata[`SWRC_CMD_ACCESS]) begin
        host_q <= swrc_pkg::RS_ACCESS;
      end else if (hwdata[`SWRC_CMD_LINK] && link_up && host_q == swrc_pkg::RS_ACCESS) begin
        host_q <= swrc_pkg::RS_LINK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, data pipe and indicator

  // picks the blink sequence of the most urgent condition
  function automatic logic [7:0] led_pick(input logic run, input swrc_pkg::swrc_run_t st);
    logic [7:0] p;
    p = 8'h00;
    if (!run) begin
      p = 8'h00;
    end else if (low_battery) begin
      p = pat_a_q[23:16];
    end else if (st == swrc_pkg::RS_LINK) begin
      p = pat_b_q[7:0];
    end else if (st == swrc_pkg::RS_ACCESS && page_active) begin
      p = pat_b_q[15:8];
    end else if (st == swrc_pkg::RS_ACCESS && link_back) begin
      p = pat_a_q[15:8];
    end else if (st == swrc_pkg::RS_ACCESS) begin
      p = pat_a_q[31:24];
    end else begin
      p = pat_a_q[7:0];
    end
    return p;
  endfunction

  // both high until startup is over, in light and deep sleep and while waking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_out_a <= 1'b1;
      status_out_b <= 1'b1;
      uart_pipe_en <= 1'b0;
    end else if (srst_q || !run_ph) begin
      status_out_a <= 1'b1;
      status_out_b <= 1'b1;
      uart_pipe_en <= 1'b0;
    end else if (run_st == swrc_pkg::RS_LINK) begin
      status_out_a <= 1'b0;
      status_out_b <= uart_active;
      uart_pipe_en <= 1'b1;
    end else begin
      status_out_a <= 1'b1;
      status_out_b <= 1'b0;
      uart_pipe_en <= 1'b0;
    end
  end

  swrc_led #(
    .STEP_CYCLES (LED_CYCLES)
  ) u_led (
    .hclk    (hclk),
    .hresetn (hresetn),
    .srst    (srst_q),
    .pattern (led_pick(run_ph, run_st)),
    .bright  (bright_q),
    .led_q   (indicator_led_out)
  );

  // read data is prepared in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (!(addr_ph && !hwrite)) begin
      hrdata <= 32'h0;
    end else if (haddr[7:0] == `SWRC_OFS_CONFIG) begin
      hrdata <= {15'h0, wdt_en_q, 4'h0, bright_q, 3'h0, trim_q};
    end else if (haddr[7:0] == `SWRC_OFS_NVMODE) begin
      hrdata <= {31'h0, nv_mode_q};
    end else if (haddr[7:0] == `SWRC_OFS_STATUS) begin
      hrdata <= {14'h0, status_out_a, status_out_b, 1'b0, wdt_cause_q, test_mode,
                 mode_q, 1'b0, run_st, 3'h0, phase_q};
    end else if (haddr[7:0] == `SWRC_OFS_LEDPAT_A) begin
      hrdata <= pat_a_q;
    end else if (haddr[7:0] == `SWRC_OFS_LEDPAT_B) begin
      hrdata <= {16'h0, pat_b_q};
    end else begin
      hrdata <= 32'h0;
    end
  end

endmodule

`default_nettype wire

// *** bench/swrc_host_model.sv ***
// host controller model: drives wake, reset and power pins, polls status
`timescale 1ns/1ps
`default_nettype none

module swrc_host_model (
  input  wire logic hclk,
  input  wire logic status_out_a,
  input  wire logic status_out_b,
  output var  logic wake_n,
  output var  logic ext_rst_n,
  output var  logic sw_btn
);
  // pins rest released and powered, so an unused reset floats high
  initial begin
    wake_n = 1'b1;
    ext_rst_n = 1'b1;
    sw_btn = 1'b1;
  end

  // two cycles low: one 40 ns cycle alone is below the minimum pulse
  task automatic pulse_rst();
    @(posedge hclk);
    ext_rst_n <= 1'b0;
    repeat (2) @(posedge hclk);
    ext_rst_n <= 1'b1;
  endtask

  // wake is a level, held long enough to pass the synchroniser
  task automatic pulse_wake();
    @(posedge hclk);
    wake_n <= 1'b0;
    repeat (4) @(posedge hclk);
    wake_n <= 1'b1;
  endtask

  // power button level, low sends the device to deep sleep
  task automatic power(input logic on);
    @(posedge hclk);
    sw_btn <= on;
  endtask

  // poll the status pins; nominal wake and boot delays are never trusted
  task automatic wait_st(input logic [1:0] code, input int n, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++) begin
      @(posedge hclk);
      ok = ({status_out_a, status_out_b} === code);
    end
  endtask
endmodule

`default_nettype wire

// *** bench/swrc_top_chk.sv ***
// port assertions of the sleep, wake, reset and mode control block
`timescale 1ns/1ps
`default_nettype none

module swrc_top_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_rst_n,
  input wire logic        uart_active,
  input wire logic        status_out_a,
  input wire logic        status_out_b,
  input wire logic [4:0]  xtal_trim,
  input wire logic        uart_pipe_en
);
  // single clock domain, so clock and disable are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////
  // bus side: never stalls, read data only in a read data phase
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_rdata_idle: assert property (hrdata != 32'h0 |->
    $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data outside a read data phase");

  ////////////////////////////////////////////////////////////////////////
  // reset: defined values and both-high status for the first eight cycles of initialisation
  chk_por_values: assert property ($rose(hresetn) |->
    xtal_trim == 5'h10 && hrdata == 32'h0)
    else $error("trim or read data wrong after power-on reset");
  chk_por_status_hh: assert property ($rose(hresetn) |->
    (status_out_a && status_out_b) [*8])
    else $error("status left both-high during power-on init");
  chk_ext_rst_hh: assert property ($fell(ext_rst_n) |->
    ##[1:6] (status_out_a && status_out_b))
    else $error("external reset did not force both-high status");
  chk_ext_init_hold: assert property ($fell(ext_rst_n) |->
    ##6 (status_out_a && status_out_b) [*8])
    else $error("status left both-high during reset init");

  ////////////////////////////////////////////////////////////////////////
  // link codes: pipe only while linked, busy code follows serial activity
  chk_pipe_link: assert property ($rose(uart_pipe_en) |->
    ##[0:1] !status_out_a)
    else $error("serial pipe opened outside the link state");
  chk_busy_code: assert property (!status_out_a && $rose(status_out_b) |->
    $past(uart_active) || $past(uart_active, 2))
    else $error("busy link code without serial activity");

  // main scenarios reached
  cov_pipe: cover property ($rose(uart_pipe_en));
  cov_ext_rst: cover property ($fell(ext_rst_n));
  cov_busy: cover property (!status_out_a && status_out_b);
  cov_read: cover property (hrdata != 32'h0);
endmodule

bind swrc_top swrc_top_chk swrc_top_chk_inst (.*);

`default_nettype wire

// *** bench/swrc_top_tb_top.sv ***
// self-checking bench: bus master, pin stimulus and read-data scoreboard
`timescale 1ns/1ps
`default_nettype none
`include "swrc_params.svh"

module swrc_top_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dph, lit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, m;
  logic        wake_n, ext_rst_n, sw_btn, strap_select, strap_pin_a, strap_pin_b;
  logic        link_up, page_active, link_back, low_battery, uart_active;
  logic        low_power_req, status_out_a, status_out_b, indicator_led_out;
  logic        uart_pipe_en;
  logic [4:0]  xtal_trim, t;
  logic [3:0]  b;
  logic [31:0] exp_q[$], msk_q[$];
  int          failures, num_checks, seed;
  localparam logic [31:0] MS = 32'h0003_171F;
  localparam logic [31:0] MI = 32'h0003_101F;
  // run phase status words: auto access, host standby
  localparam logic [31:0] RUN_ACC = 32'h0002_0202;
  localparam logic [31:0] HOST_SB = 32'h0002_1102;

  swrc_top #(.INIT_CYCLES(20), .WAKE_CYCLES(10), .WDT_CYCLES(50), .LED_CYCLES(4))
  swrc_top_inst (.hready(hreadyout), .*);

  swrc_host_model swrc_host_model_inst (.*);

  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] st(logic [4:0] ph, logic [2:0] rs, logic md,
                                     logic [1:0] pn);
    return {14'h0, pn, 3'h0, md, 1'b0, rs, 3'h0, ph};
  endfunction

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for hready at a rising edge; a hang ends the run
  task automatic wait_rdy();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        chk(32'(hreadyout), 32'h1);
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask

  // one whole word: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // note the expected value, then issue the read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic ws(input logic [1:0] c, input int n);
    bit ok;
    swrc_host_model_inst.wait_st(c, n, ok);
    chk({30'h0, status_out_a, status_out_b}, {30'h0, c});
    if (!ok) print_verdict();
  endtask

  // scoreboard: a read data phase pops the oldest note
  always @(posedge hclk) begin
    if (dph && msk_q.size() > 0) begin
      m = msk_q.pop_front();
      chk(hrdata & m, exp_q.pop_front() & m);
    end
    dph <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    seed = 57;
    hresetn = 1'b0;
    {hsel, hsize, htrans, hwrite, haddr, hwdata, dph} = '0;
    {strap_pin_a, strap_pin_b, strap_select} = 3'h6;
    {link_up, page_active, link_back, low_battery, uart_active, low_power_req} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // power-on values, status first while init still runs
    rd(`SWRC_OFS_STATUS, st(swrc_pkg::PH_INIT, 3'h0, 1'b0, 2'h3), MI);
    rd(`SWRC_OFS_CONFIG, 32'h0000_0F10, 32'h0001_1F1F);
    rd(`SWRC_OFS_LEDPAT_A, `SWRC_RST_LEDPAT_A, '1);
    rd(`SWRC_OFS_LEDPAT_B, {16'h0, `SWRC_RST_LEDPAT_B}, '1);
    rd(`SWRC_OFS_NVMODE, 32'h0, 32'h1);
    rd(8'h1C, 32'h0, '1);
    chk(32'(xtal_trim), 32'h10);
    ws(2'b10, 100);
    rd(`SWRC_OFS_STATUS, RUN_ACC, MS);
    // trim 5'h01 and top end 5'h1F plus random trim and brightness
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 5'h01 : (i == 1) ? 5'h1F : 5'($random(seed));
      b = 4'($random(seed));
      wr(`SWRC_OFS_CONFIG, {20'h0, b, 3'h0, t});
      rd(`SWRC_OFS_CONFIG, {20'h0, b, 3'h0, t}, '1);
      chk(32'(xtal_trim), 32'(t));
    end
    // dark patterns stay off, lit ones light
    wr(`SWRC_OFS_CONFIG, 32'h0000_0F10);
    for (int p = 0; p < 2; p++) begin
      {page_active, link_back, low_battery} <= 3'($random(seed));
      wr(`SWRC_OFS_LEDPAT_A, p ? 32'hFFFF_FFFF : 32'h0);
      wr(`SWRC_OFS_LEDPAT_B, p ? 32'hFFFF_FFFF : 32'h0);
      lit = 1'b0;
      repeat (64) @(posedge hclk) lit = lit | indicator_led_out;
      chk(32'(lit), 32'(p));
    end
    ////////////////////////////////////////////////////////////////////////
    // automatic machine links by itself and pipes serial data
    link_up <= 1'b1;
    uart_active <= 1'b1;
    ws(2'b01, 20);
    rd(`SWRC_OFS_STATUS, st(swrc_pkg::PH_RUN, swrc_pkg::RS_LINK, 1'b0, 2'b01), MS);
    chk(32'(uart_pipe_en), 32'h1);
    uart_active <= 1'b0;
    ws(2'b00, 10);
    link_up <= 1'b0;
    ws(2'b10, 10);
    // the serial reset command has no effect in automatic mode
    wr(`SWRC_OFS_COMMAND, 32'h1);
    rd(`SWRC_OFS_STATUS, RUN_ACC, MS);
    // external reset returns a changed trim to its initial value
    wr(`SWRC_OFS_CONFIG, 32'h0000_0F03);
    swrc_host_model_inst.pulse_rst();
    ws(2'b11, 10);
    ws(2'b10, 100);
    rd(`SWRC_OFS_CONFIG, 32'h0000_0F10, '1);
    // unkicked watchdog resets the device and records why
    wr(`SWRC_OFS_CONFIG, 32'h0001_0F10);
    ws(2'b11, 80);
    ws(2'b10, 100);
    rd(`SWRC_OFS_STATUS, 32'h4000, 32'h4000);
    rd(`SWRC_OFS_CONFIG, 32'h0000_0F10, '1);
    wr(`SWRC_OFS_STATUS, 32'h4000);
    rd(`SWRC_OFS_STATUS, 32'h0, 32'h4000);
    // light sleep, then the wake pin brings back access
    low_power_req <= 1'b1;
    ws(2'b11, 20);
    low_power_req <= 1'b0;
    rd(`SWRC_OFS_STATUS, st(swrc_pkg::PH_SLEEP, 3'h0, 1'b0, 2'h3), MI);
    swrc_host_model_inst.pulse_wake();
    ws(2'b10, 60);
    rd(`SWRC_OFS_STATUS, RUN_ACC, MS);
    ////////////////////////////////////////////////////////////////////////
    // stored mode is writable only under the test straps
    wr(`SWRC_OFS_NVMODE, 32'h1);
    rd(`SWRC_OFS_NVMODE, 32'h0, 32'h1);
    {strap_pin_a, strap_pin_b, strap_select} <= `SWRC_STRAP_TEST;
    repeat (4) @(posedge hclk);
    wr(`SWRC_OFS_NVMODE, 32'h1);
    rd(`SWRC_OFS_NVMODE, 32'h1, 32'h1);
    {strap_pin_a, strap_pin_b, strap_select} <= 3'h6;
    swrc_host_model_inst.pulse_rst();
    ws(2'b11, 10);
    ws(2'b10, 100);
    // host machine ignores a link until commanded
    link_up <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(`SWRC_OFS_STATUS, HOST_SB, MS);
    wr(`SWRC_OFS_COMMAND, 32'h8);
    rd(`SWRC_OFS_STATUS, st(swrc_pkg::PH_RUN, swrc_pkg::RS_ACCESS, 1'b1, 2'b10), MS);
    wr(`SWRC_OFS_COMMAND, 32'h10);
    ws(2'b00, 10);
    chk(32'(uart_pipe_en), 32'h1);
    link_up <= 1'b0;
    wr(`SWRC_OFS_COMMAND, 32'h1);
    ws(2'b11, 10);
    ws(2'b10, 100);
    rd(`SWRC_OFS_STATUS, HOST_SB, MS);
    // power button low gives deep sleep with both-high status
    swrc_host_model_inst.power(1'b0);
    ws(2'b11, 10);
    rd(`SWRC_OFS_STATUS, st(swrc_pkg::PH_DEEP, 3'h0, 1'b1, 2'h3), MI);
    repeat (3) @(posedge hclk);
    print_verdict();
  end
endmodule

`default_nettype wire
